// file: src/rioc_regs.vh
`ifndef RIOC_REGS_VH
`define RIOC_REGS_VH
// ==========================================================
// controller registers (apb byte addresses)
`define RIOC_OFF_CMD      12'h000
`define RIOC_OFF_ADDR     12'h004
`define RIOC_OFF_WDATA    12'h008
`define RIOC_OFF_STATUS   12'h00c
`define RIOC_OFF_RDATA    12'h010
`define RIOC_OFF_RESET    12'h014
`define RIOC_OFF_TIMING   12'h018
// ==========================================================
// command register fields
`define RIOC_CMD_GO       0
`define RIOC_CMD_WRITE    1
`define RIOC_CMD_MEM      2
// ==========================================================
// device address map, i/o section
`define RIOC_IO_PORTA     7'h20
`define RIOC_IO_PORTB     7'h21
`define RIOC_IO_DIRA      7'h22
`define RIOC_IO_DIRB      7'h23
`define RIOC_IO_MODE      7'h24
`define RIOC_BIT_PORT     3
`define RIOC_BIT_SET      4
// ==========================================================
// mode register fields
`define RIOC_MODE_STRB    5
`define RIOC_MODE_OUT     6
`define RIOC_MODE_HIZ     7
// ==========================================================
// timing in ns and cycles at 40 mhz
`define RIOC_CLK_NS       25
`define RIOC_STROBE_NS    750
`define RIOC_SETUP_NS     300
`define RIOC_HOLD_NS      50
`define RIOC_STROBE_CYC   ((`RIOC_STROBE_NS + `RIOC_CLK_NS - 1) / `RIOC_CLK_NS)
`define RIOC_SETUP_CYC    ((`RIOC_SETUP_NS + `RIOC_CLK_NS - 1) / `RIOC_CLK_NS)
`define RIOC_HOLD_CYC     ((`RIOC_HOLD_NS + `RIOC_CLK_NS - 1) / `RIOC_CLK_NS)
`define RIOC_RESET_DEF    1'b0
`endif

// file: src/rioc_sync.v
`timescale 1ns/10ps
// ==========================================================
// two flip-flop synchroniser
module rioc_sync
#(
  parameter WIDTH = 8
)
(
  // clock
  input  wire             clk,
  input  wire             rst,
  // data
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
  assign dout = sync_r;
endmodule // rioc_sync

// file: src/rioc_ctrl.v
// Operation
// - select only with low and high selects
// - memory/io high picks ram, low picks io
// - read strobe low makes device drive data
// - write strobe low makes device take data
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "rioc_regs.vh"
module rioc_ctrl
#(
  parameter STROBE_CYC = `RIOC_STROBE_CYC,
  parameter SETUP_CYC  = `RIOC_SETUP_CYC,
  parameter HOLD_CYC   = `RIOC_HOLD_CYC
)
(
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // device bus
  output reg         selectActiveLow,
  output reg         selectActiveHigh,
  output reg         memIoSelect,
  output reg  [6:0]  addressInputs,
  output reg         readStrobeN,
  output reg         writeStrobeN,
  output reg         masterResetN,
  input  wire [7:0]  dataBusIn,
  output reg  [7:0]  dataBusOut,
  output reg         dataBusOe,
  // device interrupt
  input  wire        interruptRequest
);
  // ==========================================================
  // states
  localparam ST_IDLE   = 2'd0;
  localparam ST_SETUP  = 2'd1;
  localparam ST_STROBE = 2'd2;
  localparam ST_HOLD   = 2'd3;

  // ==========================================================
  // registers and nets
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [7:0]  cnt_r;
  reg         cmdWrite_r;
  reg         cmdMem_r;
  reg  [6:0]  addr_r;
  reg  [7:0]  wdata_r;
  reg  [7:0]  rdata_r;
  reg         done_r;
  reg         resetReq_r;
  wire        busy;
  wire [7:0]  dataSync;
  wire [0:0]  irqSync;
  wire        wrAcc;
  wire        rdAcc;
  wire        cmdHit;
  wire        launch;
  wire        curWrite;
  wire        strobeEnd;
  wire        accessEnd;
  reg  [7:0]  cnt_nxt;
  reg         selOn_nxt;
  reg         memIo_nxt;
  reg  [6:0]  addrPins_nxt;
  reg  [7:0]  dataPins_nxt;
  reg         rdStrobeN_nxt;
  reg         wrStrobeN_nxt;
  reg         busOe_nxt;
  reg         devResetN_nxt;

  assign busy    = (state_r != ST_IDLE);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wrAcc   = psel && penable && pwrite;
  assign rdAcc   = psel && !penable && !pwrite;

  // ==========================================================
  // command launch and phase ends
  assign cmdHit    = wrAcc && (paddr == `RIOC_OFF_CMD);
  assign launch    = (state_r == ST_IDLE) && cmdHit && pwdata[`RIOC_CMD_GO] && !resetReq_r;
  assign curWrite  = launch ? pwdata[`RIOC_CMD_WRITE] : cmdWrite_r;
  assign strobeEnd = (state_r == ST_STROBE) && (cnt_r == 8'h00);
  assign accessEnd = (state_r == ST_HOLD) && (cnt_r == 8'h00);

  // ==========================================================
  // synchronisers for device pins
  rioc_sync #(.WIDTH(8)) u_dsync
  (
    .clk  (clk),
    .rst  (rst),
    .din  (dataBusIn),
    .dout (dataSync)
  );
  rioc_sync #(.WIDTH(1)) u_isync
  (
    .clk  (clk),
    .rst  (rst),
    .din  (interruptRequest),
    .dout (irqSync)
  );

  // ==========================================================
  // apb registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      cmdWrite_r <= 1'b0;
      cmdMem_r   <= 1'b0;
      addr_r     <= 7'h00;
      wdata_r    <= 8'h00;
      resetReq_r <= 1'b1;
    end
    else if (wrAcc)
    begin
      case (paddr)
        `RIOC_OFF_CMD:
        begin
          if (!busy)
          begin
            cmdWrite_r <= pwdata[`RIOC_CMD_WRITE];
            cmdMem_r   <= pwdata[`RIOC_CMD_MEM];
          end
        end
        `RIOC_OFF_ADDR:
          if (!busy)
            addr_r <= pwdata[6:0];
        `RIOC_OFF_WDATA:
          if (!busy)
            wdata_r <= pwdata[7:0];
        `RIOC_OFF_RESET:
          if (!busy)
            resetReq_r <= pwdata[0];
        default:
          resetReq_r <= resetReq_r;
      endcase
    end
  end

  // ==========================================================
  // read data is registered in setup phase
  always @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (rdAcc)
    begin
      case (paddr)
        `RIOC_OFF_CMD:    prdata <= {29'h0, cmdMem_r, cmdWrite_r, 1'b0};
        `RIOC_OFF_ADDR:   prdata <= {25'h0, addr_r};
        `RIOC_OFF_WDATA:  prdata <= {24'h0, wdata_r};
        `RIOC_OFF_STATUS: prdata <= {29'h0, irqSync[0], done_r, busy};
        `RIOC_OFF_RDATA:  prdata <= {24'h0, rdata_r};
        `RIOC_OFF_RESET:  prdata <= {31'h0, resetReq_r};
        `RIOC_OFF_TIMING: prdata <= {24'h0, STROBE_CYC[7:0]};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // device access sequencer
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (launch)
          state_nxt = ST_SETUP;
      ST_SETUP:
        if (cnt_r == 8'h00)
          state_nxt = ST_STROBE;
      ST_STROBE:
        if (cnt_r == 8'h00)
          state_nxt = ST_HOLD;
      ST_HOLD:
        if (cnt_r == 8'h00)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================
  // phase counter
  always @*
  begin
    cnt_nxt = cnt_r;
    if (state_r != state_nxt)
    begin
      case (state_nxt)
        ST_SETUP:  cnt_nxt = SETUP_CYC[7:0] - 8'h01;
        ST_STROBE: cnt_nxt = STROBE_CYC[7:0] + 8'h01;
        ST_HOLD:   cnt_nxt = HOLD_CYC[7:0] - 8'h01;
        default:   cnt_nxt = 8'h00;
      endcase
    end
    else if (cnt_r != 8'h00)
      cnt_nxt = cnt_r - 8'h01;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (launch)
        done_r <= 1'b0;
      if (accessEnd)
        done_r <= 1'b1;
      // sample read data at the strobe end; synchroniser delay is inside the extra cycles
      if (strobeEnd && !cmdWrite_r)
        rdata_r <= dataSync;
    end
  end

  // ==========================================================
  // device pin next values
  always @*
  begin
    selOn_nxt     = (state_nxt != ST_IDLE);
    memIo_nxt     = memIoSelect;
    addrPins_nxt  = addressInputs;
    dataPins_nxt  = dataBusOut;
    rdStrobeN_nxt = !((state_nxt == ST_STROBE) && !curWrite);
    wrStrobeN_nxt = !((state_nxt == ST_STROBE) && curWrite);
    busOe_nxt     = selOn_nxt && curWrite;
    devResetN_nxt = !resetReq_r;
    if (launch)
    begin
      memIo_nxt    = pwdata[`RIOC_CMD_MEM];
      addrPins_nxt = addr_r;
      dataPins_nxt = wdata_r;
    end
  end

  // ==========================================================
  // device pin registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      selectActiveLow  <= 1'b1;
      selectActiveHigh <= 1'b0;
      memIoSelect      <= 1'b0;
      addressInputs    <= 7'h00;
      readStrobeN      <= 1'b1;
      writeStrobeN     <= 1'b1;
      masterResetN     <= `RIOC_RESET_DEF;
      dataBusOut       <= 8'h00;
      dataBusOe        <= 1'b0;
    end
    else
    begin
      masterResetN     <= devResetN_nxt;
      selectActiveLow  <= !selOn_nxt;
      selectActiveHigh <= selOn_nxt;
      memIoSelect      <= memIo_nxt;
      addressInputs    <= addrPins_nxt;
      dataBusOut       <= dataPins_nxt;
      readStrobeN      <= rdStrobeN_nxt;
      writeStrobeN     <= wrStrobeN_nxt;
      dataBusOe        <= busOe_nxt;
    end
  end
endmodule // rioc_ctrl

// file: verif/rioc_ctrl_checker.sv
`timescale 1ns/10ps
// ==========================================================
// device bus checker
module rioc_checker #(parameter SETUP_CYC = 12)
(
  input wire        clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire        selectActiveLow, selectActiveHigh, memIoSelect,
  input wire [6:0]  addressInputs,
  input wire        readStrobeN, writeStrobeN, masterResetN,
  input wire [7:0]  dataBusIn, dataBusOut,
  input wire        dataBusOe, interruptRequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire stb = !readStrobeN || !writeStrobeN;
  wire selAct = !selectActiveLow && selectActiveHigh;
  sequence selOn; !selectActiveLow && selectActiveHigh; endsequence
  AST_SEL: assert property (stb |-> selOn)
    else $error("strobe without select");
  AST_EXCL: assert property (readStrobeN || writeStrobeN)
    else $error("both strobes low");
  AST_WROE: assert property (!writeStrobeN |-> dataBusOe)
    else $error("write without drive");
  AST_RDOE: assert property (!readStrobeN |-> !dataBusOe)
    else $error("read while driving");
  AST_ADDR: assert property (stb && $past(stb) |-> $stable(addressInputs))
    else $error("address moved");
  AST_SETUP: assert property ($rose(stb) |-> $past(selectActiveHigh, SETUP_CYC))
    else $error("select setup short");
  AST_WIDTH: assert property ($rose(stb) |-> stb [*8] ##24 stb ##1 !stb)
    else $error("strobe width");
  AST_HOLD: assert property ($fell(stb) |-> selOn ##1 selOn ##1 !selectActiveHigh)
    else $error("select hold");
  AST_RST: assert property (!masterResetN |-> !stb)
    else $error("strobe in device reset");
  AST_HELD: assert property (selAct && $past(selAct) |-> $stable(memIoSelect) && $stable(dataBusOut))
    else $error("access fields moved");
  AST_OE: assert property (selAct && $past(selAct) |-> $stable(dataBusOe))
    else $error("drive changed in access");
endmodule // rioc_checker
bind rioc_ctrl rioc_checker #(.SETUP_CYC(SETUP_CYC)) i_chk (.*);

// file: verif/rioc_dev_model.sv
`timescale 1ns/10ps
// ==========================================================
// device model
module rioc_dev_model
(
  input  wire       csL, csH, mio, rdN, wrN, rstN,
  input  wire [6:0] a,
  input  wire [7:0] din, extA, extB,
  output wire [7:0] dout,
  output wire       drv, irq
);
  logic [7:0] mem [128];
  logic [7:0] oA, oB, dA, dB, md;
  wire [7:0] pA = (dA & oA) | (~dA & extA);
  wire [7:0] pB = (dB & oB) | (~dB & extB);
  wire sel = !csL && csH && rstN;
  wire wo = !mio && a[5] && a[2:0] > 3'h1;
  assign drv = sel && !rdN && !wo;
  assign dout = mio ? mem[a] : a[5] ? (a[0] ? pB : pA)
              : {(a[3] ? pB[a[2:0]] : pA[a[2:0]]), 7'h00};
  assign irq = 1'b0;
  always @(posedge wrN or negedge rstN)
    if (!rstN)
      {oA, oB, dA, dB, md} <= '0;
    else if (sel && mio)
      mem[a] <= din;
    else if (sel && a[5])
      case (a[2:0])
        3'h0: oA <= din;
        3'h1: oB <= din;
        3'h2: dA <= din;
        3'h3: dB <= din;
        3'h4: md <= din;
        default: ;
      endcase
    else if (sel)
      if (a[3])
        oB[a[2:0]] <= a[4];
      else
        oA[a[2:0]] <= a[4];
endmodule // rioc_dev_model

// file: verif/rioc_ctrl_tb.sv
`timescale 1ns/10ps
`include "rioc_regs.vh"
// ==========================================================
// bench top
module rioc_ctrl_tb;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, csL, csH, mio, rdN, wrN, rstN, oe, irq, drv;
  logic [6:0]  a, ra [4] = '{7'h00, 7'h7f, 7'h55, 7'h2a}, ba [4] = '{7'h07, 7'h08, 7'h09, 7'h20};
  logic [7:0]  dOut, dDev, bus, lastV = 8'h00, be [4] = '{8'h80, 8'h00, 8'h80, 8'hba};
  int          mismatches = 0, nTests = 0;
  assign bus = drv ? dDev : oe ? dOut : ~lastV;
  always #12.5 clk = ~clk;
  always @(posedge clk) lastV <= bus;
  rioc_ctrl i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .selectActiveLow(csL), .selectActiveHigh(csH), .memIoSelect(mio), .addressInputs(a),
    .readStrobeN(rdN), .writeStrobeN(wrN), .masterResetN(rstN), .dataBusIn(bus),
    .dataBusOut(dOut), .dataBusOe(oe), .interruptRequest(irq));
  rioc_dev_model i_dev (.csL(csL), .csH(csH), .mio(mio), .rdN(rdN), .wrN(wrN), .rstN(rstN),
    .a(a), .din(bus), .extA(8'h33), .extB(8'h0f), .dout(dDev), .drv(drv), .irq(irq));
  // ==========================================================
  // bus tasks
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic dop(input logic [2:0] c, input logic [6:0] ad, input logic [7:0] d);
    apb(1, `RIOC_OFF_ADDR, {25'h0, ad});
    apb(1, `RIOC_OFF_WDATA, {24'h0, d});
    apb(1, `RIOC_OFF_CMD, {29'h0, c});
    apb(0, `RIOC_OFF_STATUS, '0);
    while (q[1:0] !== 2'b10) apb(0, `RIOC_OFF_STATUS, '0);
    apb(0, `RIOC_OFF_RDATA, '0);
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    nTests++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    apb(0, `RIOC_OFF_RESET, '0);
    chk("resetReg", q, 32'h1);
    apb(1, `RIOC_OFF_CMD, 32'h7);
    apb(0, `RIOC_OFF_STATUS, '0);
    chk("heldGo", q, 32'h0);
    apb(1, `RIOC_OFF_RESET, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) dop(3'h7, ra[i], {1'b0, ra[i]} ^ 8'h96);
    for (int i = 0; i < 8; i++)
    begin
      dop(3'h5, ra[i % 4], 8'h00);
      chk("ramByte", q, {24'h0, {1'b0, ra[i % 4]} ^ 8'h96});
    end
    $display("ram test done");
    dop(3'h3, `RIOC_IO_DIRA, 8'h8f);
    dop(3'h3, `RIOC_IO_PORTA, 8'h5a);
    dop(3'h3, `RIOC_IO_DIRB, 8'hff);
    dop(3'h3, `RIOC_IO_PORTB, 8'hc3);
    dop(3'h3, `RIOC_IO_MODE, 8'he0);
    dop(3'h1, `RIOC_IO_PORTA, 8'h00);
    chk("portA", q, 32'h3a);
    dop(3'h1, `RIOC_IO_PORTB, 8'h00);
    chk("portB", q, 32'hc3);
    apb(0, `RIOC_OFF_STATUS, '0);
    chk("irq", q[2], 1'b0);
    dop(3'h3, 7'h17, 8'h00);
    dop(3'h3, 7'h08, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      dop(3'h1, ba[i], 8'h00);
      chk("bitRead", q, {24'h0, be[i]});
    end
    $display("port test done");
    apb(1, `RIOC_OFF_RESET, 32'h1);
    apb(1, `RIOC_OFF_RESET, 32'h0);
    dop(3'h1, `RIOC_IO_PORTA, 8'h00);
    chk("inA", q, 32'h33);
    dop(3'h1, `RIOC_IO_PORTB, 8'h00);
    chk("inB", q, 32'h0f);
    dop(3'h5, 7'h55, 8'h00);
    chk("ramKept", q, 32'hc3);
    $display("device reset test done");
    final_report;
  end
  initial
  begin
    #(25 * 40000);
    mismatches++;
    final_report;
  end
endmodule // rioc_ctrl_tb
